// *** hdl/gpio_regs.vh ***
`ifndef GPIO_REGS_VH
`define GPIO_REGS_VH
// register indices; byte address is four times the index
`define IDX_PORT_A_DATA     5'h00
`define IDX_PORT_B_DATA     5'h01
`define IDX_PORT_C_DATA     5'h02
`define IDX_PORT_A_DIR      5'h04
`define IDX_PORT_B_DIR      5'h05
`define IDX_PORT_C_DIR      5'h06
`define IDX_PORT_C_PULL     5'h0F
`define IDX_PORT_A_PULL     5'h10
`define IDX_PORT_B_PULL     5'h11
// field positions
`define BIT_SLOW_EDGE       3
`define BIT_PB_UNUSED       3
`define BIT_REG_DISABLE     6
`define BIT_COMPARE_SEL     7
// reset values
`define RST_DIR             8'h00
`define RST_PULL            8'h00
// port-B pins with pull-ups, open-drain when driven
`define PB_PULLUP_MASK      8'h06
`define PB_USED_MASK        8'hF7
`define PC_USED_MASK        8'h0F
// port-C direction bits five and four do not exist
`define PC_DIR_USED_MASK    8'hCF
// half-cycle delay of the bit-two falling edge, in ns, and at 100 MHz
`define CLK_PERIOD_NS       10
`define SLOW_DELAY_NS       5
`define READ_UNMAPPED       32'h00000000
`endif

// *** hdl/three_port_gpio_block.v ***
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "gpio_regs.vh"

// PULL_OPTION zero builds the block without pull resistors: every pull
// enable then stays low whatever software writes to the pull registers.
// IRQ_OPTION zero leaves the port-A low nibble as plain I/O only.
module three_port_gpio_block #(
	parameter PULL_OPTION = 1,
	parameter IRQ_OPTION  = 1
) (
	// register bus
	input  wire        clk,
	input  wire        arst_n,
	input  wire [6:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	// port A pins
	input  wire [7:0]  portAIn,
	output wire [7:0]  portAOut,
	output wire [7:0]  portAOe,
	output wire [7:0]  portAPullDown,
	// port B pins
	input  wire [7:0]  portBIn,
	output wire [7:0]  portBOut,
	output wire [7:0]  portBOe,
	output wire [7:0]  portBPullDown,
	output wire [7:0]  portBPullUp,
	// port C pins
	input  wire [3:0]  portCIn,
	output wire [3:0]  portCOut,
	output wire [3:0]  portCOe,
	output wire [3:0]  portCPullDown,
	// timer and supply side
	input  wire        timerCompareOutput,
	output wire        timerCaptureInput,
	output wire        regulatorDisable,
	output wire        slowEdgeActive,
	output wire [3:0]  externalIrqInputs
);

	////////////////////////////////////////////////////////////////////////////////
	// registers

	reg  [7:0]  portAData;
	reg  [7:0]  portBData;
	reg  [7:0]  portCData;
	reg  [7:0]  portADirection;
	reg  [7:0]  portBDirectionSlew;
	reg  [7:0]  portCDirectionMisc;
	reg  [7:0]  portAPullControl;
	reg  [7:0]  portBPullControl;
	reg  [7:0]  portCPullControl;
	// bus handshake state and the delayed sink of port-B bit two
	reg         answered;
	reg         bitTwoLate;
	reg  [31:0] next_readdata;

	wire [7:0]  pinA;
	wire [7:0]  pinB;
	wire [3:0]  pinC;
	wire [4:0]  regIndex;
	wire        access;
	wire        writeNow;
	wire [7:0]  wrByte;
	wire        slowEdge;
	wire [7:0]  portBDir;
	wire        bitTwoDrivesLow;
	wire        sinkBitOne;
	wire        sinkBitTwo;
	// one select per register
	wire        selAData;
	wire        selBData;
	wire        selCData;
	wire        selADir;
	wire        selBDir;
	wire        selCDir;
	wire        selAPull;
	wire        selBPull;
	wire        selCPull;

	// the word address is the register index; byte lane zero carries the data
	assign regIndex = address[6:2];
	assign access   = read | write;
	// one wait cycle, then the access completes
	assign waitrequest = access & ~answered;
	// a write with lane zero disabled completes normally but changes nothing
	// so a master that only touches the upper lanes cannot corrupt a register
	assign writeNow = write & answered & byteenable[0];
	assign wrByte   = writedata[7:0];

	// the selects keep the write decoder readable; the read multiplexer below
	// decodes the same index values straight from the header
	assign selAData = (regIndex == `IDX_PORT_A_DATA);
	assign selBData = (regIndex == `IDX_PORT_B_DATA);
	assign selCData = (regIndex == `IDX_PORT_C_DATA);
	assign selADir  = (regIndex == `IDX_PORT_A_DIR);
	assign selBDir  = (regIndex == `IDX_PORT_B_DIR);
	assign selCDir  = (regIndex == `IDX_PORT_C_DIR);
	assign selAPull = (regIndex == `IDX_PORT_A_PULL);
	assign selBPull = (regIndex == `IDX_PORT_B_PULL);
	assign selCPull = (regIndex == `IDX_PORT_C_PULL);

	// answered marks the second cycle of a request and drops again right after
	// completion, so a request that follows at once still gets its wait cycle
	// and never completes on stale read data; the cost is a fixed two-cycle
	// access even for registers that could answer at once
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			answered <= 1'b0;
		end else begin
			answered <= access & ~answered;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// data latches carry no reset: their contents survive it
	// a latch written while its pin is still an input sets the level that
	// the pin shows once it turns to output, so no stray level appears then

	always @(posedge clk) begin
		if (writeNow && selAData) begin
			portAData <= wrByte;
		end
		if (writeNow && selBData) begin
			portBData <= wrByte & `PB_USED_MASK;
		end
		if (writeNow && selCData) begin
			portCData <= wrByte & `PC_USED_MASK;
		end
	end

	// direction and pull registers clear to zero at reset
	// pull registers are write-only: software keeps its own copy if it needs one
	// the slow-edge, regulator and compare switches share the direction words
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portADirection     <= `RST_DIR;
			portBDirectionSlew <= `RST_DIR;
			portCDirectionMisc <= `RST_DIR;
			portAPullControl   <= `RST_PULL;
			portBPullControl   <= `RST_PULL;
			portCPullControl   <= `RST_PULL;
		end else if (writeNow) begin
			if (selADir) begin
				portADirection <= wrByte;
			end
			if (selBDir) begin
				portBDirectionSlew <= wrByte;
			end
			if (selCDir) begin
				portCDirectionMisc <= wrByte & `PC_DIR_USED_MASK;
			end
			if (selAPull) begin
				portAPullControl <= wrByte;
			end
			if (selBPull) begin
				portBPullControl <= wrByte & `PB_USED_MASK;
			end
			if (selCPull) begin
				portCPullControl <= wrByte & `PC_USED_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin input synchronisers: a change counts once stages two and three agree
	// a pin change therefore reaches the read path three to four cycles later

	// port A: the low nibble also feeds the interrupt inputs
	pin_sync #(
		.W(8)
	) syncPortA (
		.clk      (clk),
		.arst_n   (arst_n),
		.pinIn    (portAIn),
		.pinLevel (pinA)
	);

	// port B: bit zero also feeds the timer capture input
	pin_sync #(
		.W(8)
	) syncPortB (
		.clk      (clk),
		.arst_n   (arst_n),
		.pinIn    (portBIn),
		.pinLevel (pinB)
	);

	// port C: four pins only
	pin_sync #(
		.W(4)
	) syncPortC (
		.clk      (clk),
		.arst_n   (arst_n),
		.pinIn    (portCIn),
		.pinLevel (pinC)
	);

	////////////////////////////////////////////////////////////////////////////////
	// read path: outputs read their latch, inputs read the pin
	// the word is captured in the wait cycle, so it shows the pins as they
	// stood one cycle before the access completes

	always @* begin
		next_readdata = `READ_UNMAPPED;
		case (regIndex)
			`IDX_PORT_A_DATA: begin
				next_readdata[7:0] = (portAData & portADirection) | (pinA & ~portADirection);
			end
			`IDX_PORT_B_DATA: begin
				next_readdata[7:0] = ((portBData & portBDir) | (pinB & ~portBDir))
					& `PB_USED_MASK;
			end
			`IDX_PORT_C_DATA: begin
				next_readdata[3:0] = (portCData[3:0] & portCDirectionMisc[3:0])
					| (pinC & ~portCDirectionMisc[3:0]);
			end
			`IDX_PORT_A_DIR: begin
				next_readdata[7:0] = portADirection;
			end
			`IDX_PORT_B_DIR: begin
				next_readdata[7:0] = portBDirectionSlew;
			end
			`IDX_PORT_C_DIR: begin
				next_readdata[7:0] = portCDirectionMisc;
			end
			// pull registers are write-only and read as zero
			default: begin
				next_readdata = `READ_UNMAPPED;
			end
		endcase
	end

	// read data is loaded once per read, in its wait cycle, and then stands
	// until the next read; writes never disturb it
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			readdata <= 32'h00000000;
		end else if (read && !answered) begin
			readdata <= next_readdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin drive: shared controls and port A
	// every enable and pull here is a plain function of registers, so a pin
	// follows its write in the cycle after the bus access completes

	// bit three of the port-B direction holds the slow-edge switch, not a pin
	assign slowEdge = portBDirectionSlew[`BIT_SLOW_EDGE];
	assign portBDir = portBDirectionSlew & `PB_USED_MASK;
	assign slowEdgeActive = slowEdge;

	// port A: push-pull when output, pull-down only while an input; a driven
	// pin would otherwise fight its own pull-down and waste supply current
	assign portAOut = portAData;
	assign portAOe  = portADirection;
	assign portAPullDown = (PULL_OPTION != 0) ? (~portAPullControl & ~portADirection)
		: 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// pin drive: port B

	// bit two falls half a cycle late: its sink starts on the falling clock
	// edge after the data goes low; this is the one negedge flop in the block.
	// only the falling edge is delayed: a rising latch releases the sink at
	// once, so the pin is never held low longer than software asked for;
	// the flop sits on the same clock, so no crossing is introduced
	always @(negedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bitTwoLate <= 1'b0;
		end else begin
			bitTwoLate <= ~portBData[2];
		end
	end
	assign bitTwoDrivesLow = slowEdge ? (bitTwoLate & ~portBData[2]) : ~portBData[2];

	// open-drain bits sink only while they are outputs holding a zero; a one
	// lets the line float up to its pull-up or to the board's own level
	assign sinkBitOne = portBDir[1] & ~portBData[1];
	assign sinkBitTwo = portBDir[2] & bitTwoDrivesLow;

	// bits one and two only sink; the others are push-pull
	assign portBOut = portBData & ~`PB_PULLUP_MASK;
	assign portBOe  = {portBDir[7:3], sinkBitTwo, sinkBitOne, portBDir[0]};
	// pull-ups stay active on open-drain outputs; pull-downs need an input
	// the pull-up needs no direction term: a sinking bit overrides it anyway
	assign portBPullUp = (PULL_OPTION != 0) ? (~portBPullControl & `PB_PULLUP_MASK)
		: 8'h00;
	assign portBPullDown = (PULL_OPTION != 0)
		? (~portBPullControl & ~portBDir & `PB_USED_MASK & ~`PB_PULLUP_MASK) : 8'h00;

	// capture input forced low while bit zero drives, so the pin's own output
	// can never raise a capture event in the timer
	assign timerCaptureInput = portBDir[0] ? 1'b0 : pinB[0];

	////////////////////////////////////////////////////////////////////////////////
	// pin drive: port C and side signals

	// port C: pin zero may carry the compare output; its enable still follows
	// the direction bit, so software must make pin zero an output as well
	assign portCOut = {portCData[3:1], portCDirectionMisc[`BIT_COMPARE_SEL]
		? timerCompareOutput : portCData[0]};
	assign portCOe  = portCDirectionMisc[3:0];
	assign portCPullDown = (PULL_OPTION != 0)
		? (~portCPullControl[3:0] & ~portCDirectionMisc[3:0]) : 4'h0;

	// the regulator bit only leaves the block; the supply logic acts on it
	assign regulatorDisable = portCDirectionMisc[`BIT_REG_DISABLE];
	// interrupt inputs take the filtered level, so a glitch shorter than one
	// cycle on a pin never reaches the interrupt logic
	assign externalIrqInputs = (IRQ_OPTION != 0) ? pinA[3:0] : 4'h0;

endmodule // three_port_gpio_block

////////////////////////////////////////////////////////////////////////////////
// three-flop pin synchroniser with an agreement filter: the filtered level
// only moves once stages two and three hold the same value, so a pin that
// bounces for a single cycle never reaches the registers; after reset every
// stage is low, so a pin reads low until its level has passed the filter

module pin_sync #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire         arst_n,
	input  wire [W-1:0] pinIn,
	output reg  [W-1:0] pinLevel
);

	reg  [W-1:0] stage1;
	reg  [W-1:0] stage2;
	reg  [W-1:0] stage3;

	// only stage two reads stage one; the filter looks at stages two and three
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1   <= {W{1'b0}};
			stage2   <= {W{1'b0}};
			stage3   <= {W{1'b0}};
			pinLevel <= {W{1'b0}};
		end else begin
			stage1   <= pinIn;
			stage2   <= stage1;
			stage3   <= stage2;
			pinLevel <= (stage2 & stage3) | (pinLevel & (stage2 | stage3));
		end
	end

endmodule // pin_sync

// *** tb/pin_model.sv ***
`timescale 1ns/1ps
//////////////////////////////////////////
// board side of one port: own drive wins, then board drive, then pull;
// a floating line shows the inverse of the board value so no stale level passes
module pin_model #(
	parameter W = 8
) (
	input  wire  [W-1:0] o, e, pd, pu, x, xe,
	output logic [W-1:0] p
);
	always_comb begin
		for (int i = 0; i < W; i++) begin
			p[i] = e[i] ? o[i] : xe[i] ? x[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : ~x[i];
		end
	end
endmodule // pin_model

// *** tb/gpio_checker.sv ***
`timescale 1ns/1ps
//////////////////////////////////////////
module gpio_checker (
	input wire        clk, arst_n, read, write, waitrequest, timerCompareOutput,
	input wire        timerCaptureInput, regulatorDisable, slowEdgeActive,
	input wire [6:0]  address,
	input wire [31:0] writedata,
	input wire [3:0]  byteenable, portCOut, portCOe,
	input wire [7:0]  portAOe, portAPullDown, portBOut, portBOe, portBPullUp
);
	// a write lands on the edge where waitrequest is seen low
	wire       wr = write && !waitrequest && byteenable[0];
	wire [4:0] ix = address[6:2];
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_AOE: assert property (wr && ix == 5'h04 |=> portAOe == $past(writedata[7:0]))
		else $error("port A enable wrong");
	AST_APULL: assert property ((portAPullDown & portAOe) == 8'h00)
		else $error("pull on driven pin");
	AST_BOD: assert property (portBOut[2:1] == 2'h0)
		else $error("open drain pin drives high");
	AST_CAP: assert property (portBOe[0] |-> !timerCaptureInput)
		else $error("capture not held low");
	AST_SLOW: assert property (wr && ix == 5'h05 |=> slowEdgeActive == $past(writedata[3]))
		else $error("slow edge bit wrong");
	AST_DIRC: assert property (wr && ix == 5'h06 |=> portCOe == $past(writedata[3:0]))
		else $error("port C enable wrong");
	AST_PC0: assert property (wr && ix == 5'h06 && writedata[7] && writedata[0]
		|=> portCOut[0] == timerCompareOutput) else $error("compare not on pin");
	AST_VR: assert property (wr && ix == 5'h06 |=> regulatorDisable == $past(writedata[6]))
		else $error("regulator bit wrong");
	AST_BPU: assert property (wr && ix == 5'h11 |=> portBPullUp == (~$past(writedata[7:0]) & 8'h06))
		else $error("pull-up wrong");
endmodule // gpio_checker
bind three_port_gpio_block gpio_checker chk_i (.*);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
//////////////////////////////////////////
module tb_top;
	logic        clk = 0, arst_n = 0, read = 0, write = 0, tcmp = 0;
	logic [6:0]  address = 7'h00;
	logic [31:0] writedata = 32'h0, q;
	logic [3:0]  byteenable = 4'hF, xC = 4'h0, xeC = 4'h0;
	logic [7:0]  xA = 8'h00, xB = 8'h00, xeA = 8'h00, xeB = 8'h00;
	wire  [31:0] readdata;
	wire         waitrequest, cap, vr, slow;
	wire  [7:0]  aO, aE, aPd, aIn, bO, bE, bPd, bPu, bIn;
	wire  [3:0]  cO, cE, cPd, cIn, irq;
	int          fail_count = 0, checks_done = 0, cyc = 0;
	three_port_gpio_block dut (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .portAIn(aIn), .portAOut(aO), .portAOe(aE),
		.portAPullDown(aPd), .portBIn(bIn), .portBOut(bO), .portBOe(bE), .portBPullDown(bPd),
		.portBPullUp(bPu), .portCIn(cIn), .portCOut(cO), .portCOe(cE), .portCPullDown(cPd),
		.timerCompareOutput(tcmp), .timerCaptureInput(cap), .regulatorDisable(vr),
		.slowEdgeActive(slow), .externalIrqInputs(irq));
	pin_model pa (.o(aO), .e(aE), .pd(aPd), .pu(8'h00), .x(xA), .xe(xeA), .p(aIn));
	pin_model pb (.o(bO), .e(bE), .pd(bPd), .pu(bPu), .x(xB), .xe(xeB), .p(bIn));
	pin_model #(.W(4)) pc (.o(cO), .e(cE), .pd(cPd), .pu(4'h0), .x(xC), .xe(xeC), .p(cIn));
	initial forever #5 clk = ~clk;
	// a hang is cut short well past the expected hundred or so cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	// one access, held until waitrequest is seen low at a rising edge; data taken there
	task automatic acc(input logic [4:0] ix, input logic w, input logic [7:0] d);
		@(posedge clk);
		address <= {ix, 2'b00};
		write <= w;
		read <= !w;
		writedata <= {24'h0, d};
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [4:0] ix, input logic [31:0] exp);
		acc(ix, 1'b0, 8'h00);
		chk(q, exp);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		rd(5'h04, 32'h0);
		rd(5'h05, 32'h0);
		rd(5'h06, 32'h0);
		chk(aPd, 8'hFF);
		chk(bPu, 8'h06);
		chk(bPd, 8'hF1);
		chk({cPd, cE}, 8'hF0);
		// latch must survive a second reset
		acc(5'h00, 1'b1, 8'h5A);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		chk(aE, 8'h00);
		acc(5'h04, 1'b1, 8'hFF);
		rd(5'h00, 32'h5A);
		$display("test reset done");
		@(posedge clk);
		xeA <= 8'hFF;
		xA <= 8'hC3;
		acc(5'h04, 1'b1, 8'h0F);
		acc(5'h00, 1'b1, 8'hA5);
		chk(aE, 8'h0F);
		chk(aO[3:0], 4'h5);
		repeat (6) @(posedge clk);
		rd(5'h00, 32'hC5);
		chk(irq, 4'h5);
		acc(5'h10, 1'b1, 8'h0F);
		chk(aPd, 8'hF0);
		rd(5'h10, 32'h0);
		$display("test port A done");
		@(posedge clk);
		xeB <= 8'hFF;
		xB <= 8'hF9;
		acc(5'h05, 1'b1, 8'h0F);
		acc(5'h01, 1'b1, 8'h06);
		chk(slow, 1'b1);
		chk(cap, 1'b0);
		chk(bE & 8'hF7, 8'h01);
		acc(5'h01, 1'b1, 8'h00);
		chk(bE[2], 1'b0);
		@(negedge clk);
		#1 chk(bE[2], 1'b1);
		repeat (6) @(posedge clk);
		rd(5'h01, 32'hF0);
		acc(5'h05, 1'b1, 8'h00);
		repeat (6) @(posedge clk);
		chk({slow, cap}, 2'h1);
		$display("test port B done");
		acc(5'h06, 1'b1, 8'hF1);
		rd(5'h06, 32'hC1);
		chk(vr, 1'b1);
		@(posedge clk);
		tcmp <= 1'b1;
		@(negedge clk);
		chk(cO[0], 1'b1);
		acc(5'h02, 1'b1, 8'h00);
		acc(5'h06, 1'b1, 8'h01);
		chk({vr, cO[0]}, 2'h0);
		acc(5'h0F, 1'b1, 8'h03);
		chk(cPd, 4'hC);
		acc(5'h03, 1'b1, 8'hFF);
		rd(5'h03, 32'h0);
		$display("test port C done");
		test_done();
	end
endmodule // tb_top
